// file: design/pic_pkg.sv
package pic_pkg;
    // ------------
    // Register offsets
    // ------------
    localparam logic [6:0] ADDR_CFG_DATA = 7'h4d;
    localparam logic [6:0] ADDR_CFG_SEL = 7'h4e;
    localparam logic [6:0] ADDR_GAIN_FLUX = 7'h54;
    localparam logic [6:0] ADDR_GAIN_TORQUE = 7'h55;
    localparam logic [6:0] ADDR_GAIN_SPEED = 7'h56;
    localparam logic [6:0] ADDR_GAIN_POS = 7'h57;
    localparam logic [6:0] ADDR_OUT_LIM = 7'h5d;
    localparam logic [6:0] ADDR_CUR_LIM = 7'h5e;
    localparam logic [6:0] ADDR_SPD_LIM = 7'h60;
    localparam logic [6:0] ADDR_POS_LO = 7'h61;
    localparam logic [6:0] ADDR_POS_HI = 7'h62;
    localparam logic [6:0] ADDR_MODE = 7'h63;
    localparam logic [6:0] ADDR_TGT_CUR = 7'h64;
    localparam logic [6:0] ADDR_TGT_SPD = 7'h65;
    localparam logic [6:0] ADDR_TGT_POS = 7'h66;
    localparam logic [6:0] ADDR_EXT_VOLT = 7'h67;
    localparam logic [31:0] CFG_SEL_GAIN_FMT = 32'h0000_003e;
    // ------------
    // Reset values and field positions
    // ------------
    localparam logic [31:0] RST_LIM16 = 32'h0000_7fff;
    localparam logic [31:0] RST_LIM32 = 32'h7fff_ffff;
    localparam logic [31:0] RST_POS_LO = 32'h8000_0000;
    localparam logic [15:0] RST_LFSR = 16'h0001;
    localparam int MODE_STRUCT_BIT = 8;
    localparam int MODE_DECIM_LSB = 16;
    localparam logic [4:0] SH_Q88 = 5'h08;
    localparam logic [4:0] SH_Q412 = 5'h0c;
    localparam logic [4:0] SH_CLASSIC_POS = 5'h10;
    localparam logic [4:0] SH_CLASSIC_INT = 5'h10;
    localparam logic [6:0] SH_ADV_INT = 7'h08;
    // ------------
    // Timing
    // ------------
    localparam int unsigned CLK_HZ = 32'h0262_5a00;
    localparam int unsigned CUR_INT_US = 32'h0000_0020;
    localparam int unsigned SLOW_INT_US = 32'h0000_0100;
    localparam int unsigned CUR_INT_CYC = CLK_HZ / 32'h000f_4240 * CUR_INT_US;
    localparam int unsigned SLOW_INT_CYC = CLK_HZ / 32'h000f_4240 * SLOW_INT_US;
    // ------------
    // Types
    // ------------
    typedef enum logic [2:0] {LVL_OFF, LVL_TORQUE, LVL_SPEED, LVL_POS, LVL_VOLT} pic_level_t;
    typedef enum logic [1:0] {SRC_REG, SRC_PRBS, SRC_ANALOG, SRC_PWM} pic_source_t;
    typedef struct packed {
        logic [15:0] p;
        logic [15:0] i;
        logic [4:0] p_shift;
        logic [4:0] i_shift;
    } pic_gain_t;
    // ------------
    // Functions
    // ------------
    function automatic logic signed [31:0] clip_range(input logic signed [79:0] v,
        input logic signed [31:0] lo, input logic signed [31:0] hi);
        clip_range = (v > hi) ? hi : ((v < lo) ? lo : v[31:0]);
    endfunction

    function automatic logic signed [31:0] clip_sym(input logic signed [79:0] v, input logic [31:0] lim);
        clip_sym = clip_range(v, $signed(32'h0000_0000 - lim), $signed(lim));
    endfunction

    function automatic pic_level_t mode_level(input logic [3:0] m);
        case (m)
            4'h1, 4'h4, 4'h5, 4'ha, 4'hd: mode_level = LVL_TORQUE;
            4'h2, 4'h6, 4'hb, 4'he: mode_level = LVL_SPEED;
            4'h3, 4'h7, 4'hc, 4'hf: mode_level = LVL_POS;
            4'h8: mode_level = LVL_VOLT;
            default: mode_level = LVL_OFF;
        endcase
    endfunction

    function automatic pic_source_t mode_source(input logic [3:0] m);
        case (m)
            4'h5, 4'h6, 4'h7: mode_source = SRC_PRBS;
            4'ha, 4'hb, 4'hc: mode_source = SRC_ANALOG;
            4'hd, 4'he, 4'hf: mode_source = SRC_PWM;
            default: mode_source = SRC_REG;
        endcase
    endfunction
endpackage

// file: design/pic_stage.sv
`timescale 1ns/10ps
module pic_stage (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // control
    input wire logic clear_in,
    input wire logic advanced_in,
    input wire logic sample_in,
    input wire logic int_tick_in,
    input wire pic_pkg::pic_gain_t gain_in,
    // data
    input wire logic signed [31:0] target_in,
    input wire logic signed [31:0] actual_in,
    input wire logic [31:0] limit_in,
    output logic signed [31:0] result_out
);
    typedef struct packed {
        logic signed [47:0] integ;
        logic signed [31:0] result;
    } pic_stage_state_t;

    pic_stage_state_t st;
    pic_stage_state_t next_st;
    logic signed [63:0] err;
    logic signed [63:0] prop;
    logic signed [63:0] iterm;
    logic signed [63:0] cand_term;
    logic signed [47:0] cand;
    logic signed [79:0] inc;
    logic signed [31:0] adv;
    logic [6:0] adv_shift;

    always_comb
    begin
        next_st = st;
        err = 64'(target_in) - 64'(actual_in);
        prop = (err * 64'($signed(gain_in.p))) >>> gain_in.p_shift;
        cand = st.integ + err[47:0];
        cand_term = (64'(cand) * 64'($signed(gain_in.i))) >>> gain_in.i_shift;
        iterm = (64'(st.integ) * 64'($signed(gain_in.i))) >>> gain_in.i_shift;
        adv_shift = 7'(gain_in.p_shift) + 7'(gain_in.i_shift) + pic_pkg::SH_ADV_INT;
        inc = (80'(err) * 80'($signed(gain_in.p)) * 80'($signed(gain_in.i))) >>> adv_shift;
        adv = pic_pkg::clip_sym(80'(st.integ) + inc, limit_in);
        if (clear_in)
        begin
            next_st = '0;
        end
        else if (!advanced_in)
        begin
            // Error sum stays where integral term would exceed the limit
            if (int_tick_in && cand_term <= $signed(64'(limit_in)) && cand_term >= -$signed(64'(limit_in)))
            begin
                next_st.integ = cand;
            end
            next_st.result = pic_pkg::clip_sym(80'(prop) + 80'(iterm), limit_in);
        end
        else if (sample_in)
        begin
            next_st.integ = 48'(adv);
            // Output takes the integrator as it stood before this update
            next_st.result = pic_pkg::clip_sym(80'(prop) + 80'(st.integ), limit_in);
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign result_out = st.result;
endmodule

// file: design/pic_top.sv
// Function
// - Classic output is P times error plus I-sum
// - Current targets s16, speed/position targets s32
// - Position feeds speed feeds current feeds voltage
// - Classic current: P/256, I/65536 every 32us
// - Classic speed P/256, position P/65536, 256us
// - Modes 0-8: off, control, test, voltage
// - 9 reserved, 10-15 analog or pulse targets
// - Advanced integrator adds P*I*error/256 each update
// - Advanced updates per PWM, position decimated
// - Gain formats set through indirect select 0x3e
// - Advanced: each gain scaled /256 or /4096 independently
// - Targets and outputs clipped; limits reset maximal
// - Classic sum held, advanced integrator clipped
// - Current output, current input, speed input limits
// - Position target has low and high limit
// - Current and speed gains q8.8 and q0.16
// - Classic position P q0.16, advanced q8.8
// - One structure select for whole cascade
// - Enable low: regulators off, PWM at center
`timescale 1ns/10ps
module pic_top #(
    parameter int unsigned SLOW_INT_CYC = pic_pkg::SLOW_INT_CYC
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // register port
    input wire logic reg_write_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    // enable pin
    input wire logic external_enable_input_in,
    // timing and measurements
    input wire logic pwm_cycle_in,
    input wire logic signed [15:0] flux_actual_in,
    input wire logic signed [15:0] torque_actual_in,
    input wire logic signed [31:0] speed_actual_in,
    input wire logic signed [31:0] position_actual_in,
    // alternative target sources
    input wire logic signed [15:0] analog_target_input_in,
    input wire logic signed [15:0] pwm_target_in,
    // voltage outputs and status
    output logic signed [15:0] voltage_d_out,
    output logic signed [15:0] voltage_q_out,
    output logic pwm_center_out,
    output logic regulators_active_out
);
    localparam int ST_FLUX = 0;
    localparam int ST_TORQUE = 1;
    localparam int ST_SPEED = 2;
    localparam int ST_POS = 3;

    typedef struct packed {
        logic [31:0] cfg_sel;
        logic [7:0] gain_fmt;
        logic [3:0][31:0] gain;
        logic [31:0] out_lim;
        logic [31:0] cur_lim;
        logic [31:0] spd_lim;
        logic [31:0] pos_lo;
        logic [31:0] pos_hi;
        logic [3:0] motion;
        logic advanced;
        logic [6:0] decim;
        logic [31:0] tgt_cur;
        logic [31:0] tgt_spd;
        logic [31:0] tgt_pos;
        logic [31:0] ext_volt;
        logic ena_meta;
        logic ena;
        logic [10:0] cur_cnt;
        logic [23:0] slow_cnt;
        logic [6:0] decim_cnt;
        logic [15:0] lfsr;
        logic [31:0] rdata;
        logic signed [15:0] vd;
        logic signed [15:0] vq;
        logic center;
        logic active;
    } pic_top_state_t;

    // ------------
    // Reset release
    // ------------
    logic [1:0] rst_pipe;
    logic rstn_sync;

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_pipe <= 2'h0;
        end
        else
        begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rstn_sync = rst_pipe[1];

    // ------------
    // Declarations
    // ------------
    pic_top_state_t st;
    pic_top_state_t next_st;
    pic_pkg::pic_level_t lvl;
    pic_pkg::pic_source_t src;
    pic_pkg::pic_gain_t [3:0] gain;
    logic signed [31:0] tgt [4];
    logic signed [31:0] act [4];
    logic [31:0] lim [4];
    logic signed [31:0] res [4];
    logic [3:0] clear;
    logic [3:0] sample;
    logic [3:0] tick;
    logic [3:0] stage_on;
    logic cur_tick;
    logic slow_tick;
    logic pos_sample;
    logic flux_prbs;
    logic signed [15:0] src16;
    logic signed [31:0] ext32;
    logic signed [31:0] spd_raw;
    logic signed [31:0] tq_raw;
    logic signed [31:0] flux_raw;
    logic lfsr_fb;

    // ------------
    // Mode decode and target routing
    // ------------
    always_comb
    begin
        lvl = pic_pkg::mode_level(st.motion);
        src = pic_pkg::mode_source(st.motion);
        flux_prbs = (st.motion == 4'h4);
        case (src)
            pic_pkg::SRC_PRBS: src16 = $signed(st.lfsr);
            pic_pkg::SRC_ANALOG: src16 = analog_target_input_in;
            pic_pkg::SRC_PWM: src16 = pwm_target_in;
            default: src16 = flux_prbs ? $signed(st.lfsr) : 16'sh0000;
        endcase
        ext32 = 32'(src16);
        stage_on[ST_FLUX] = (lvl == pic_pkg::LVL_TORQUE) || (lvl == pic_pkg::LVL_SPEED) || (lvl == pic_pkg::LVL_POS);
        stage_on[ST_TORQUE] = stage_on[ST_FLUX];
        stage_on[ST_SPEED] = (lvl == pic_pkg::LVL_SPEED) || (lvl == pic_pkg::LVL_POS);
        stage_on[ST_POS] = (lvl == pic_pkg::LVL_POS);
        // Position target, bounded by its own low and high limits
        tgt[ST_POS] = pic_pkg::clip_range(80'((src == pic_pkg::SRC_REG) ? $signed(st.tgt_pos) : ext32),
            $signed(st.pos_lo), $signed(st.pos_hi));
        // Speed target comes from position stage in position mode
        if (lvl == pic_pkg::LVL_POS)
        begin
            spd_raw = res[ST_POS];
        end
        else
        begin
            spd_raw = (src == pic_pkg::SRC_REG) ? $signed(st.tgt_spd) : ext32;
        end
        tgt[ST_SPEED] = pic_pkg::clip_sym(80'(spd_raw), st.spd_lim);
        if (stage_on[ST_SPEED])
        begin
            tq_raw = res[ST_SPEED];
        end
        else
        begin
            tq_raw = (src == pic_pkg::SRC_REG) ? 32'($signed(st.tgt_cur[31:16])) : ext32;
        end
        flux_raw = flux_prbs ? ext32 : 32'($signed(st.tgt_cur[15:0]));
        tgt[ST_TORQUE] = pic_pkg::clip_sym(80'(tq_raw), {16'h0000, st.cur_lim[15:0]});
        tgt[ST_FLUX] = pic_pkg::clip_sym(80'(flux_raw), {16'h0000, st.cur_lim[15:0]});
        act[ST_FLUX] = 32'(flux_actual_in);
        act[ST_TORQUE] = 32'(torque_actual_in);
        act[ST_SPEED] = speed_actual_in;
        act[ST_POS] = position_actual_in;
        // Each stage output is bounded by what the next stage accepts
        lim[ST_FLUX] = {16'h0000, st.out_lim[15:0]};
        lim[ST_TORQUE] = {16'h0000, st.out_lim[15:0]};
        lim[ST_SPEED] = {16'h0000, st.cur_lim[15:0]};
        lim[ST_POS] = st.spd_lim;
    end

    // ------------
    // Update strobes and gain scaling
    // ------------
    always_comb
    begin
        cur_tick = (st.cur_cnt == 11'(pic_pkg::CUR_INT_CYC - 1));
        slow_tick = (st.slow_cnt == 24'(SLOW_INT_CYC - 1));
        pos_sample = pwm_cycle_in && (st.decim_cnt == 7'h00);
        lfsr_fb = st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10];
        for (int k = 0; k < 4; k++)
        begin
            clear[k] = !st.ena || !stage_on[k];
            gain[k].p = st.gain[k][31:16];
            gain[k].i = st.gain[k][15:0];
            if (st.advanced)
            begin
                gain[k].p_shift = st.gain_fmt[2 * k] ? pic_pkg::SH_Q412 : pic_pkg::SH_Q88;
                gain[k].i_shift = st.gain_fmt[2 * k + 1] ? pic_pkg::SH_Q412 : pic_pkg::SH_Q88;
            end
            else
            begin
                gain[k].p_shift = (k == ST_POS) ? pic_pkg::SH_CLASSIC_POS : pic_pkg::SH_Q88;
                gain[k].i_shift = pic_pkg::SH_CLASSIC_INT;
            end
        end
        sample = {pos_sample, pwm_cycle_in, pwm_cycle_in, pwm_cycle_in};
        tick = {slow_tick, slow_tick, cur_tick, cur_tick};
    end

    // ------------
    // Regulator cascade
    // ------------
    for (genvar g = 0; g < 4; g++)
    begin : g_stage
        pic_stage u_stage (
            .clock_in(clock_in),
            .rstn_in(rstn_sync),
            .clear_in(clear[g]),
            .advanced_in(st.advanced),
            .sample_in(sample[g]),
            .int_tick_in(tick[g]),
            .gain_in(gain[g]),
            .target_in(tgt[g]),
            .actual_in(act[g]),
            .limit_in(lim[g]),
            .result_out(res[g])
        );
    end

    // ------------
    // Registers, counters and outputs
    // ------------
    always_comb
    begin
        next_st = st;
        next_st.ena_meta = external_enable_input_in;
        next_st.ena = st.ena_meta;
        next_st.cur_cnt = cur_tick ? 11'h000 : st.cur_cnt + 11'h001;
        next_st.slow_cnt = slow_tick ? 24'h00_0000 : st.slow_cnt + 24'h00_0001;
        if (pwm_cycle_in)
        begin
            next_st.decim_cnt = (st.decim_cnt >= st.decim) ? 7'h00 : st.decim_cnt + 7'h01;
            next_st.lfsr = {st.lfsr[14:0], lfsr_fb};
        end
        if (reg_write_in)
        begin
            case (reg_addr_in)
                pic_pkg::ADDR_CFG_DATA:
                begin
                    if (st.cfg_sel == pic_pkg::CFG_SEL_GAIN_FMT)
                    begin
                        next_st.gain_fmt = reg_wdata_in[7:0];
                    end
                end
                pic_pkg::ADDR_CFG_SEL: next_st.cfg_sel = reg_wdata_in;
                pic_pkg::ADDR_GAIN_FLUX: next_st.gain[ST_FLUX] = reg_wdata_in;
                pic_pkg::ADDR_GAIN_TORQUE: next_st.gain[ST_TORQUE] = reg_wdata_in;
                pic_pkg::ADDR_GAIN_SPEED: next_st.gain[ST_SPEED] = reg_wdata_in;
                pic_pkg::ADDR_GAIN_POS: next_st.gain[ST_POS] = reg_wdata_in;
                pic_pkg::ADDR_OUT_LIM: next_st.out_lim = reg_wdata_in;
                pic_pkg::ADDR_CUR_LIM: next_st.cur_lim = reg_wdata_in;
                pic_pkg::ADDR_SPD_LIM: next_st.spd_lim = reg_wdata_in;
                pic_pkg::ADDR_POS_LO: next_st.pos_lo = reg_wdata_in;
                pic_pkg::ADDR_POS_HI: next_st.pos_hi = reg_wdata_in;
                pic_pkg::ADDR_MODE:
                begin
                    next_st.motion = reg_wdata_in[3:0];
                    next_st.advanced = reg_wdata_in[pic_pkg::MODE_STRUCT_BIT];
                    next_st.decim = reg_wdata_in[pic_pkg::MODE_DECIM_LSB +: 7];
                end
                pic_pkg::ADDR_TGT_CUR: next_st.tgt_cur = reg_wdata_in;
                pic_pkg::ADDR_TGT_SPD: next_st.tgt_spd = reg_wdata_in;
                pic_pkg::ADDR_TGT_POS: next_st.tgt_pos = reg_wdata_in;
                pic_pkg::ADDR_EXT_VOLT: next_st.ext_volt = reg_wdata_in;
                default: next_st.cfg_sel = st.cfg_sel;
            endcase
        end
        case (reg_addr_in)
            pic_pkg::ADDR_CFG_DATA:
                next_st.rdata = (st.cfg_sel == pic_pkg::CFG_SEL_GAIN_FMT) ? {24'h00_0000, st.gain_fmt} : 32'h0000_0000;
            pic_pkg::ADDR_CFG_SEL: next_st.rdata = st.cfg_sel;
            pic_pkg::ADDR_GAIN_FLUX: next_st.rdata = st.gain[ST_FLUX];
            pic_pkg::ADDR_GAIN_TORQUE: next_st.rdata = st.gain[ST_TORQUE];
            pic_pkg::ADDR_GAIN_SPEED: next_st.rdata = st.gain[ST_SPEED];
            pic_pkg::ADDR_GAIN_POS: next_st.rdata = st.gain[ST_POS];
            pic_pkg::ADDR_OUT_LIM: next_st.rdata = st.out_lim;
            pic_pkg::ADDR_CUR_LIM: next_st.rdata = st.cur_lim;
            pic_pkg::ADDR_SPD_LIM: next_st.rdata = st.spd_lim;
            pic_pkg::ADDR_POS_LO: next_st.rdata = st.pos_lo;
            pic_pkg::ADDR_POS_HI: next_st.rdata = st.pos_hi;
            pic_pkg::ADDR_MODE:
                next_st.rdata = {9'h000, st.decim, 7'h00, st.advanced, 4'h0, st.motion};
            pic_pkg::ADDR_TGT_CUR: next_st.rdata = st.tgt_cur;
            pic_pkg::ADDR_TGT_SPD: next_st.rdata = st.tgt_spd;
            pic_pkg::ADDR_TGT_POS: next_st.rdata = st.tgt_pos;
            pic_pkg::ADDR_EXT_VOLT: next_st.rdata = st.ext_volt;
            default: next_st.rdata = 32'h0000_0000;
        endcase
        // Disabled drive means zero voltage, which the PWM renders as center
        next_st.center = !st.ena;
        next_st.active = st.ena && stage_on[ST_FLUX];
        if (!st.ena || lvl == pic_pkg::LVL_OFF)
        begin
            next_st.vd = 16'sh0000;
            next_st.vq = 16'sh0000;
        end
        else if (lvl == pic_pkg::LVL_VOLT)
        begin
            next_st.vd = $signed(st.ext_volt[15:0]);
            next_st.vq = $signed(st.ext_volt[31:16]);
        end
        else
        begin
            next_st.vd = res[ST_FLUX][15:0];
            next_st.vq = res[ST_TORQUE][15:0];
        end
    end

    always_ff @(posedge clock_in or negedge rstn_sync)
    begin
        if (!rstn_sync)
        begin
            st <= '0;
            st.out_lim <= pic_pkg::RST_LIM16;
            st.cur_lim <= pic_pkg::RST_LIM16;
            st.spd_lim <= pic_pkg::RST_LIM32;
            st.pos_lo <= pic_pkg::RST_POS_LO;
            st.pos_hi <= pic_pkg::RST_LIM32;
            st.lfsr <= pic_pkg::RST_LFSR;
            st.center <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign voltage_d_out = st.vd;
    assign voltage_q_out = st.vq;
    assign pwm_center_out = st.center;
    assign regulators_active_out = st.active;
endmodule

// file: test/pic_top_assertions.sv
`timescale 1ns/10ps
module pic_top_assertions (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // register port
    input wire logic reg_write_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    // enable and outputs
    input wire logic external_enable_input_in,
    input wire logic signed [15:0] voltage_d_out,
    input wire logic signed [15:0] voltage_q_out,
    input wire logic pwm_center_out,
    input wire logic regulators_active_out
);
    // ------------
    // Properties
    // ------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    sequence s_mode(logic [3:0] c);
        reg_write_in && reg_addr_in == pic_pkg::ADDR_MODE && reg_wdata_in[3:0] == c;
    endsequence

    property p_readback(logic [6:0] a);
        reg_write_in && reg_addr_in == a ##1 !reg_write_in && reg_addr_in == a |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty

    chk_out_lim_readback: assert property (p_readback(pic_pkg::ADDR_OUT_LIM))
        else $error("output limit readback wrong");
    chk_pos_lo_readback: assert property (p_readback(pic_pkg::ADDR_POS_LO))
        else $error("position low limit readback wrong");
    chk_stop_inactive: assert property (s_mode(4'h0) |-> ##[1:4] !regulators_active_out)
        else $error("stopped mode left regulators active");
    chk_reserved_inactive: assert property (s_mode(4'h9) |-> ##[1:4] !regulators_active_out)
        else $error("reserved mode left regulators active");
    chk_stop_clears: assert property (s_mode(4'h0) |-> ##[1:6]
        (voltage_d_out == 16'h0000 && voltage_q_out == 16'h0000))
        else $error("stopped mode did not clear voltages");
    chk_torque_active: assert property ((external_enable_input_in [*8] ##0 s_mode(4'h1))
        ##1 (external_enable_input_in && !reg_write_in) [*2] |=> regulators_active_out)
        else $error("torque mode not active");
    chk_enable_low: assert property (!external_enable_input_in [*5] |-> pwm_center_out
        && !regulators_active_out && voltage_q_out == 16'h0000 && voltage_d_out == 16'h0000)
        else $error("enable low did not stop regulators");
    chk_enable_high: assert property (external_enable_input_in [*8] |-> !pwm_center_out)
        else $error("drive held at center while enabled");

    c_stop: cover property (s_mode(4'h0));
    c_drop: cover property ($fell(external_enable_input_in));
    c_active: cover property ($rose(regulators_active_out));
endmodule

bind pic_top pic_top_assertions u_chk (.clock_in(clock_in), .rstn_in(rstn_in),
    .reg_write_in(reg_write_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .external_enable_input_in(external_enable_input_in),
    .voltage_d_out(voltage_d_out), .voltage_q_out(voltage_q_out), .pwm_center_out(pwm_center_out),
    .regulators_active_out(regulators_active_out));

// file: test/tb.sv
`timescale 1ns/10ps
module tb;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic reg_write_in = 1'b0;
    logic [6:0] reg_addr_in = 7'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic external_enable_input_in = 1'b0;
    logic pwm_cycle_in = 1'b0;
    logic signed [15:0] analog_target_input_in = 16'h0020;
    logic [31:0] reg_rdata_out;
    logic signed [15:0] voltage_d_out;
    logic signed [15:0] voltage_q_out;
    logic pwm_center_out;
    logic regulators_active_out;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    // Short slow-loop count keeps the run brief
    pic_top #(.SLOW_INT_CYC(64)) DUT (.clock_in(clock_in), .rstn_in(rstn_in), .reg_write_in(reg_write_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .external_enable_input_in(external_enable_input_in), .pwm_cycle_in(pwm_cycle_in),
        .flux_actual_in(16'h0000), .torque_actual_in(16'h0000), .speed_actual_in(32'h0000_0000),
        .position_actual_in(32'h0000_0000), .analog_target_input_in(analog_target_input_in),
        .pwm_target_in(16'h0000),
        .voltage_d_out(voltage_d_out), .voltage_q_out(voltage_q_out), .pwm_center_out(pwm_center_out),
        .regulators_active_out(regulators_active_out));

    initial forever #12.5 clock_in = ~clock_in;

    // ------------
    // Shared tasks
    // ------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    // Strobe dropped before return so back-to-back writes never collide
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        reg_write_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clock_in);
        reg_write_in = 1'b0;
        @(negedge clock_in);
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] exp, input string name);
        reg_addr_in = a;
        @(negedge clock_in);
        check(name, reg_rdata_out, exp);
    endtask
    task automatic pulse;
        pwm_cycle_in = 1'b1;
        @(negedge clock_in);
        pwm_cycle_in = 1'b0;
        tick(4);
    endtask
    task give_verdict;
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------
    // Scenarios
    // ------------
    task test_reset;
        rd(pic_pkg::ADDR_OUT_LIM, 32'h0000_7fff, "out_lim");
        rd(pic_pkg::ADDR_CUR_LIM, 32'h0000_7fff, "cur_lim");
        rd(pic_pkg::ADDR_SPD_LIM, 32'h7fff_ffff, "spd_lim");
        rd(pic_pkg::ADDR_POS_LO, 32'h8000_0000, "pos_lo");
        rd(pic_pkg::ADDR_POS_HI, 32'h7fff_ffff, "pos_hi");
        rd(7'h7f, 32'h0000_0000, "unmapped");
    endtask
    task test_classic;
        wr(pic_pkg::ADDR_GAIN_TORQUE, 32'h0100_0000);
        wr(pic_pkg::ADDR_TGT_CUR, 32'h0064_0000);
        wr(pic_pkg::ADDR_MODE, 32'h0000_0001);
        tick(8);
        check("vq_prop", voltage_q_out, 32'h0000_0064);
        check("vd_zero", voltage_d_out, 32'h0000_0000);
        wr(pic_pkg::ADDR_OUT_LIM, 32'h0000_0032);
        rd(pic_pkg::ADDR_OUT_LIM, 32'h0000_0032, "out_lim_rb");
        tick(8);
        check("vq_out_clip", voltage_q_out, 32'h0000_0032);
        wr(pic_pkg::ADDR_CUR_LIM, 32'h0000_0014);
        wr(pic_pkg::ADDR_POS_LO, 32'hffff_0000);
        rd(pic_pkg::ADDR_POS_LO, 32'hffff_0000, "pos_lo_rb");
        tick(8);
        check("vq_in_clip", voltage_q_out, 32'h0000_0014);
        // Error sum still empty, so raising I here cannot make the output jump
        wr(pic_pkg::ADDR_GAIN_TORQUE, 32'h0100_7fff);
        tick(8000);
        check("vq_integral", voltage_q_out, 32'h0000_0032);
    endtask
    task test_advanced;
        wr(pic_pkg::ADDR_MODE, 32'h0000_0000);
        wr(pic_pkg::ADDR_OUT_LIM, 32'h0000_7fff);
        wr(pic_pkg::ADDR_CUR_LIM, 32'h0000_7fff);
        wr(pic_pkg::ADDR_GAIN_TORQUE, 32'h0100_4000);
        wr(pic_pkg::ADDR_TGT_CUR, 32'h03e8_0000);
        wr(pic_pkg::ADDR_MODE, 32'h0000_0101);
        pulse;
        check("adv_first", voltage_q_out, 32'h0000_03e8);
        pulse;
        check("adv_second", voltage_q_out, 32'h0000_04e2);
        wr(pic_pkg::ADDR_CFG_SEL, pic_pkg::CFG_SEL_GAIN_FMT);
        wr(pic_pkg::ADDR_CFG_DATA, 32'h0000_0004);
        rd(pic_pkg::ADDR_CFG_DATA, 32'h0000_0004, "fmt_rb");
        wr(pic_pkg::ADDR_MODE, 32'h0000_0000);
        wr(pic_pkg::ADDR_MODE, 32'h0000_0101);
        pulse;
        check("adv_q412", voltage_q_out, 32'h0000_003e);
    endtask
    task test_modes;
        wr(pic_pkg::ADDR_EXT_VOLT, 32'h1234_0567);
        wr(pic_pkg::ADDR_GAIN_TORQUE, 32'h0100_0000);
        for (int m = 0; m < 16; m++)
        begin
            wr(pic_pkg::ADDR_MODE, {28'h0000_000, m[3:0]});
            tick(6);
            check("active", regulators_active_out, (m != 0 && m != 8 && m != 9));
            if (m == 0 || m == 9)
                check("vq_stop", voltage_q_out, 32'h0000_0000);
            if (m == 8)
                check("vq_ext", {voltage_q_out, voltage_d_out}, 32'h1234_0567);
            if (m == 10)
                check("vq_analog", voltage_q_out, 32'h0000_0020);
        end
    endtask
    task test_enable;
        external_enable_input_in = 1'b0;
        tick(6);
        check("center_off", {pwm_center_out, regulators_active_out, voltage_q_out}, 32'h0002_0000);
        external_enable_input_in = 1'b1;
        tick(10);
        check("center_on", pwm_center_out, 32'h0000_0000);
    endtask

    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_errors++;
            give_verdict;
        end
    end

    initial
    begin
        tick(12);
        rstn_in = 1'b1;
        tick(4);
        external_enable_input_in = 1'b1;
        test_reset;
        test_classic;
        test_advanced;
        test_modes;
        test_enable;
        give_verdict;
    end
endmodule
